//--- design/gcr_pkg.sv
// Purpose: constants for the global configuration register block
// Assumes: AXI4-Lite byte addressing, 32-bit data
// Notes: eight-channel diagnostics, one byte each
package gcr_pkg;
   localparam int GCR_CHANNELS = 8;
   // ===========================================
   // register byte addresses
   localparam logic [7:0] GCR_ADDR_CONFIG = 8'h68;
   localparam logic [7:0] GCR_ADDR_DIAG_BASE = 8'h00;
   localparam logic [7:0] GCR_ADDR_COLD = 8'h20;
   localparam logic [7:0] GCR_ADDR_COLD_CLR = 8'h24;
   localparam logic [7:0] GCR_ADDR_STATUS = 8'h28;
   // ===========================================
   // configuration field positions
   localparam int GCR_BIT_FREEZE = 7;
   localparam int GCR_BIT_REALIGN = 6;
   localparam int GCR_BIT_HWRST_DIS = 5;
   localparam int GCR_BIT_LED_EN = 4;
   localparam int GCR_BIT_RESERVED = 3;
   localparam int GCR_BIT_GATE_DIS = 2;
   localparam int GCR_BIT_OL_DIS = 1;
   localparam int GCR_BIT_SOFT_RST = 0;
   localparam logic [7:0] GCR_CONFIG_RESET = 8'h00;
   // ===========================================
   // channel diagnostic field positions
   localparam int GCR_DIAG_GATE = 0;
   localparam int GCR_DIAG_OLA = 1;
   localparam int GCR_DIAG_OLI = 2;
   localparam logic [7:0] GCR_DIAG_RESET = 8'h00;
   localparam logic [7:0] GCR_GATE_MASK = 8'h01;
   localparam logic [7:0] GCR_OL_MASK = 8'h06;
   // ===========================================
   // bus answers
   localparam logic [1:0] GCR_RESP_OKAY = 2'b00;
   localparam logic [1:0] GCR_RESP_SLVERR = 2'b10;
   // ===========================================
   // transfer realign timing
   localparam int GCR_REALIGN_NS = 100;
   localparam int GCR_CLK_NS = 10;
   localparam int GCR_REALIGN_CYCLES = (GCR_REALIGN_NS + GCR_CLK_NS - 1) / GCR_CLK_NS;
   typedef enum logic [1:0] {GCR_XFER_RUN, GCR_XFER_WAIT_HIGH, GCR_XFER_REALIGN} gcr_xfer_type;
endpackage

//--- design/gcr_diag_gate.sv
// Purpose: per-channel diagnostic byte with masking and freeze
// Assumes: raw flags synchronous to clk
// Notes: one instance per channel
`timescale 1ns/1ps
module gcr_diag_gate
   import gcr_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic clearAll,
   input wire logic hold,
   input wire logic gateDisable,
   input wire logic openLoadDisable,
   // raw flags
   input wire logic [7:0] rawDiag,
   // stored value
   output logic [7:0] diagValue
);
   logic [7:0] next_diagValue;

   // ===========================================
   // masking
   always_comb begin
      next_diagValue = rawDiag;
      if (gateDisable) begin
         next_diagValue = next_diagValue & ~GCR_GATE_MASK;
      end
      if (openLoadDisable) begin
         next_diagValue = next_diagValue & ~GCR_OL_MASK;
      end
   end

   // ===========================================
   // storage
   always_ff @(posedge clk) begin
      if (rst || clearAll) begin
         diagValue <= GCR_DIAG_RESET;
      end else if (!hold) begin
         diagValue <= next_diagValue;
      end
   end
endmodule

//--- design/gcr_global_config.sv
// Behaviour
// - freeze bit set: diagnostics held from frame-align fall to next rise
// - freeze bit clear: diagnostics update whatever the frame-align level
// - cold-lamp read bits may still be cleared while frozen
// - freeze bit ignored whenever realign enable is set
// - realign on: frame-align edges only realign the transfer
// - realign on: drive data crosses only while frame-align high
// - realign on: host pulses frame-align low; device realigns transfer on that pulse
// - latch-strobe hardware reset honoured unless hardware-reset disable or LED matrix enable set
// - LED matrix enable runs serial matrix and masks hardware reset
// - gate-fault disable keeps gate faults out of channel diagnostics
// - open-load disable keeps both open-load flags out of diagnostics
// - soft reset clears user registers, restarts transfer, self-clears
//
// Purpose: global configuration register with AXI4-Lite access
// Assumes: frameAlign and latchStrobe synchronous to clk
// Notes: hwReset and latch reset are synchronous pulses
`timescale 1ns/1ps
module gcr_global_config
   import gcr_pkg::*;
#(
   parameter int CHANNELS = GCR_CHANNELS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // pins
   input wire logic frameAlign,
   input wire logic latchStrobeReset,
   // diagnostic sources
   input wire logic [CHANNELS*8-1:0] rawDiag,
   input wire logic [7:0] rawColdLamp,
   // drive path
   input wire logic [CHANNELS-1:0] driveIn,
   output logic [CHANNELS-1:0] driveOut,
   // device-wide effects
   output logic ledMatrixSerial,
   output logic userReset,
   output logic transferRestart
);
   logic [7:0] cfgReg;
   logic [CHANNELS*8-1:0] diagAll;
   logic [7:0] coldLamp;
   logic frameAlignDly;
   logic frozen;
   logic freezeActive;
   logic fallEdge;
   logic riseEdge;
   logic hwResetHit;
   logic clearAll;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic awHeld;
   logic wHeld;
   logic doWrite;
   logic [7:0] coldClear;
   gcr_xfer_type xferState;
   logic [7:0] realignCount;
   logic [7:0] next_coldLamp;

   assign fallEdge = frameAlignDly && !frameAlign;
   assign riseEdge = !frameAlignDly && frameAlign;
   assign freezeActive = cfgReg[GCR_BIT_FREEZE] && !cfgReg[GCR_BIT_REALIGN];
   assign hwResetHit = latchStrobeReset && !cfgReg[GCR_BIT_HWRST_DIS] && !cfgReg[GCR_BIT_LED_EN];
   assign clearAll = (doWrite && awAddr == GCR_ADDR_CONFIG && wStrb[0] && wData[GCR_BIT_SOFT_RST])
      || hwResetHit;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;

   // ===========================================
   // frame-align edge tracking
   always_ff @(posedge clk) begin
      if (rst) begin
         frameAlignDly <= 1'b1;
      end else begin
         frameAlignDly <= frameAlign;
      end
   end

   // ===========================================
   // freeze window
   always_ff @(posedge clk) begin
      if (rst || !freezeActive) begin
         frozen <= 1'b0;
      end else if (fallEdge) begin
         frozen <= 1'b1;
      end else if (riseEdge) begin
         frozen <= 1'b0;
      end
   end

   // ===========================================
   // channel diagnostics
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      gcr_diag_gate u_gate (
         .clk(clk),
         .rst(rst),
         .clearAll(clearAll),
         .hold(frozen || (freezeActive && fallEdge)),
         .gateDisable(cfgReg[GCR_BIT_GATE_DIS]),
         .openLoadDisable(cfgReg[GCR_BIT_OL_DIS]),
         .rawDiag(rawDiag[ch*8 +: 8]),
         .diagValue(diagAll[ch*8 +: 8])
      );
   end

   // ===========================================
   // cold-lamp register, read bits clearable while frozen
   always_comb begin
      next_coldLamp = coldLamp & ~coldClear;
      if (!(frozen || (freezeActive && fallEdge))) begin
         next_coldLamp = next_coldLamp | rawColdLamp;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || clearAll) begin
         coldLamp <= GCR_DIAG_RESET;
      end else begin
         coldLamp <= next_coldLamp;
      end
   end

   assign coldClear = (doWrite && awAddr == GCR_ADDR_COLD_CLR && wStrb[0]) ? wData[7:0] : 8'h00;

   // ===========================================
   // configuration register
   always_ff @(posedge clk) begin
      if (rst || hwResetHit) begin
         cfgReg <= GCR_CONFIG_RESET;
      end else if (doWrite && awAddr == GCR_ADDR_CONFIG && wStrb[0]) begin
         if (wData[GCR_BIT_SOFT_RST]) begin
            cfgReg <= GCR_CONFIG_RESET;
         end else begin
            cfgReg <= wData[7:0];
         end
      end
   end

   // ===========================================
   // cross-isolation transfer control
   always_ff @(posedge clk) begin
      if (rst || clearAll) begin
         xferState <= GCR_XFER_REALIGN;
         realignCount <= 8'(GCR_REALIGN_CYCLES);
      end else begin
         case (xferState)
            GCR_XFER_RUN: begin
               if (cfgReg[GCR_BIT_REALIGN] && fallEdge) begin
                  xferState <= GCR_XFER_WAIT_HIGH;
               end
            end
            GCR_XFER_WAIT_HIGH: begin
               if (frameAlign) begin
                  xferState <= GCR_XFER_REALIGN;
                  realignCount <= 8'(GCR_REALIGN_CYCLES);
               end
            end
            GCR_XFER_REALIGN: begin
               if (realignCount <= 8'h01) begin
                  xferState <= GCR_XFER_RUN;
               end else begin
                  realignCount <= realignCount - 8'h01;
               end
            end
            default: xferState <= GCR_XFER_RUN;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         driveOut <= '0;
      end else if (xferState == GCR_XFER_RUN && (!cfgReg[GCR_BIT_REALIGN] || frameAlign)) begin
         driveOut <= driveIn;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         transferRestart <= 1'b0;
         userReset <= 1'b0;
         ledMatrixSerial <= 1'b0;
      end else begin
         transferRestart <= clearAll;
         userReset <= clearAll;
         ledMatrixSerial <= cfgReg[GCR_BIT_LED_EN];
      end
   end

   // ===========================================
   // axi4-lite write channel
   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= GCR_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr == GCR_ADDR_CONFIG || awAddr == GCR_ADDR_COLD_CLR)
               ? GCR_RESP_OKAY : GCR_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !awHeld;
   assign s_axi_wready = !wHeld;

   // ===========================================
   // axi4-lite read channel
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= GCR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= GCR_RESP_OKAY;
         s_axi_rdata <= 32'h0;
         if (s_axi_araddr == GCR_ADDR_CONFIG) begin
            s_axi_rdata <= {24'h0, cfgReg};
         end else if (s_axi_araddr == GCR_ADDR_COLD) begin
            s_axi_rdata <= {24'h0, coldLamp};
         end else if (s_axi_araddr == GCR_ADDR_STATUS) begin
            s_axi_rdata <= {28'h0, frozen, xferState == GCR_XFER_RUN, cfgReg[GCR_BIT_REALIGN], frameAlign};
         end else if (s_axi_araddr < GCR_ADDR_DIAG_BASE + 8'(CHANNELS * 4) && s_axi_araddr[1:0] == 2'b00) begin
            s_axi_rdata <= {24'h0, diagAll[s_axi_araddr[7:2]*8 +: 8]};
         end else begin
            s_axi_rresp <= GCR_RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ===========================================
   // checks
   sequence s_fall_frozen;
      freezeActive && fallEdge;
   endsequence

   property p_freeze_hold;
      @(posedge clk) disable iff (rst)
      s_fall_frozen ##1 (freezeActive && !frameAlign && !clearAll) |=> $stable(diagAll);
   endproperty
   a_freeze_hold: assert property (p_freeze_hold) else $error("diag changed while frozen");

   property p_no_freeze_when_off;
      @(posedge clk) disable iff (rst) !freezeActive |=> !frozen;
   endproperty
   a_no_freeze_when_off: assert property (p_no_freeze_when_off) else $error("frozen with freeze off");

   property p_cold_clear;
      @(posedge clk) disable iff (rst)
      (coldClear != 8'h00) |=> ((coldLamp & $past(coldClear) & ~$past(rawColdLamp)) == 8'h00);
   endproperty
   a_cold_clear: assert property (p_cold_clear) else $error("cold-lamp bits not cleared");

   property p_realign_no_freeze;
      @(posedge clk) disable iff (rst) cfgReg[GCR_BIT_REALIGN] |=> !frozen;
   endproperty
   a_realign_no_freeze: assert property (p_realign_no_freeze) else $error("freeze under realign");

   property p_drive_high_only;
      @(posedge clk) disable iff (rst) (cfgReg[GCR_BIT_REALIGN] && !frameAlign) |=> $stable(driveOut);
   endproperty
   a_drive_high_only: assert property (p_drive_high_only) else $error("drive moved while frame-align low");

   property p_realign_start;
      @(posedge clk) disable iff (rst || clearAll)
      (xferState == GCR_XFER_RUN && cfgReg[GCR_BIT_REALIGN] && fallEdge) |=> xferState == GCR_XFER_WAIT_HIGH;
   endproperty
   a_realign_start: assert property (p_realign_start) else $error("pulse did not start realign");

   property p_hw_reset;
      @(posedge clk) disable iff (rst) hwResetHit |=> (cfgReg == GCR_CONFIG_RESET);
   endproperty
   a_hw_reset: assert property (p_hw_reset) else $error("latch reset not honoured");

   property p_led_blocks_reset;
      @(posedge clk) disable iff (rst) cfgReg[GCR_BIT_LED_EN] |-> !hwResetHit;
   endproperty
   a_led_blocks_reset: assert property (p_led_blocks_reset) else $error("reset passed with matrix on");

   property p_gate_masked;
      @(posedge clk) disable iff (rst) cfgReg[GCR_BIT_GATE_DIS] ##1 cfgReg[GCR_BIT_GATE_DIS] |-> !diagAll[GCR_DIAG_GATE];
   endproperty
   a_gate_masked: assert property (p_gate_masked) else $error("gate fault reported when disabled");

   property p_ol_masked;
      @(posedge clk) disable iff (rst) cfgReg[GCR_BIT_OL_DIS] ##1 cfgReg[GCR_BIT_OL_DIS] |-> !diagAll[GCR_DIAG_OLA];
   endproperty
   a_ol_masked: assert property (p_ol_masked) else $error("open load reported when disabled");

   property p_soft_reset;
      @(posedge clk) disable iff (rst) clearAll |=> (!cfgReg[GCR_BIT_SOFT_RST] && transferRestart && diagAll == '0);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");
endmodule

//--- sim/gcr_host_pins.sv
// Purpose: host-side pin driver for frame-align and latch-strobe reset
// Assumes: pins change just after a rising clk edge
// Notes: frame-align idles high between pulses
`timescale 1ns/1ps
module gcr_host_pins (
   // clock
   input wire logic clk,
   // pins toward the device
   output logic frameAlign,
   output logic latchStrobeReset
);
   // ===========================================
   // idle levels
   initial begin
      frameAlign = 1'b1;
      latchStrobeReset = 1'b0;
   end
   // ===========================================
   // pin tasks
   task automatic setFrame(input logic level);
      @(posedge clk);
      frameAlign <= level;
   endtask
   task automatic strobe();
      @(posedge clk);
      latchStrobeReset <= 1'b1;
      @(posedge clk);
      latchStrobeReset <= 1'b0;
   endtask
endmodule

//--- sim/gcr_global_config_tb_top.sv
// Purpose: self-checking bench for the global configuration register
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes: expectations come from field positions in the package
`timescale 1ns/1ps
module gcr_global_config_tb_top
   import gcr_pkg::*;
();
   logic clk = 1'b0;
   logic rst;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic frameAlign, latchStrobeReset, ledMatrixSerial, userReset, transferRestart;
   logic [63:0] rawDiag;
   logic [7:0] rawColdLamp, driveIn, driveOut;
   int failCount = 0, checksDone = 0, userPulses = 0, restartPulses = 0, p, q;
   logic [7:0] cfgTab [3] = '{8'h00, 8'h04, 8'h02};
   logic [7:0] diagTab [3] = '{8'h07, 8'h06, 8'h01};
   logic [7:0] hwTab [3] = '{8'h04, 8'h24, 8'h14};
   logic [7:0] hwExp [3] = '{8'h00, 8'h24, 8'h14};
   int hwPulse [3] = '{1, 0, 0};
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (userReset === 1'b1) userPulses++;
      if (transferRestart === 1'b1) restartPulses++;
   end
   // ===========================================
   // design and host pins
   gcr_global_config #(.CHANNELS(8)) dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .frameAlign(frameAlign), .latchStrobeReset(latchStrobeReset),
      .rawDiag(rawDiag), .rawColdLamp(rawColdLamp), .driveIn(driveIn), .driveOut(driveOut),
      .ledMatrixSerial(ledMatrixSerial), .userReset(userReset), .transferRestart(transferRestart));
   gcr_host_pins host (.clk(clk), .frameAlign(frameAlign), .latchStrobeReset(latchStrobeReset));
   // ===========================================
   // checking and closing
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ===========================================
   // bus tasks
   task automatic axiWrite(input logic [7:0] addr, input logic [7:0] data, input logic [1:0] expResp,
      input logic [3:0] strb = 4'hf);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= addr;
      s_axi_wdata <= {24'h0, data};
      s_axi_wstrb <= strb;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      if (s_axi_bvalid !== 1'b1) failCount++;
      s_axi_bready <= 1'b0;
      check(32'(s_axi_bresp), 32'(expResp));
   endtask
   task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp, input logic [1:0] expResp);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= addr;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      if (s_axi_rvalid !== 1'b1) failCount++;
      s_axi_rready <= 1'b0;
      check(s_axi_rdata, {24'h0, exp});
      check(32'(s_axi_rresp), 32'(expResp));
   endtask
   task automatic diagAll(input logic [7:0] exp);
      for (int n = 0; n < 8; n++) begin
         readCheck(GCR_ADDR_DIAG_BASE + 8'(4 * n), exp, GCR_RESP_OKAY);
      end
   endtask
   // ===========================================
   // watchdog
   initial begin
      #200us;
      failCount++;
      summarize();
   end
   // ===========================================
   // tests
   initial begin
      rst <= 1'b1;
      s_axi_awaddr <= 8'h00;
      s_axi_araddr <= 8'h00;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'h0;
      rawDiag <= {8{8'h07}};
      rawColdLamp <= 8'h00;
      driveIn <= 8'h00;
      idle(2);
      rst <= 1'b0;
      readCheck(GCR_ADDR_CONFIG, GCR_CONFIG_RESET, GCR_RESP_OKAY);
      readCheck(8'h7c, 8'h00, GCR_RESP_SLVERR);
      axiWrite(8'h7c, 8'h00, GCR_RESP_SLVERR);
      axiWrite(GCR_ADDR_CONFIG, 8'h04, GCR_RESP_OKAY, 4'he);
      readCheck(GCR_ADDR_CONFIG, GCR_CONFIG_RESET, GCR_RESP_OKAY);
      for (int i = 0; i < 3; i++) begin
         axiWrite(GCR_ADDR_CONFIG, cfgTab[i], GCR_RESP_OKAY);
         idle(4);
         diagAll(diagTab[i]);
      end
      axiWrite(GCR_ADDR_CONFIG, 8'h80, GCR_RESP_OKAY);
      host.setFrame(1'b0);
      idle(3);
      rawDiag <= {8{8'h01}};
      idle(4);
      diagAll(8'h07);
      readCheck(GCR_ADDR_STATUS, 8'h0c, GCR_RESP_OKAY);
      host.setFrame(1'b1);
      idle(4);
      diagAll(8'h01);
      axiWrite(GCR_ADDR_CONFIG, 8'h00, GCR_RESP_OKAY);
      host.setFrame(1'b0);
      idle(3);
      rawDiag <= {8{8'h07}};
      idle(4);
      diagAll(8'h07);
      host.setFrame(1'b1);
      rawColdLamp <= 8'h01;
      idle(1);
      rawColdLamp <= 8'h00;
      readCheck(GCR_ADDR_COLD, 8'h01, GCR_RESP_OKAY);
      axiWrite(GCR_ADDR_CONFIG, 8'h80, GCR_RESP_OKAY);
      host.setFrame(1'b0);
      idle(3);
      axiWrite(GCR_ADDR_COLD_CLR, 8'h01, GCR_RESP_OKAY);
      readCheck(GCR_ADDR_COLD, 8'h00, GCR_RESP_OKAY);
      host.setFrame(1'b1);
      axiWrite(GCR_ADDR_CONFIG, 8'hc0, GCR_RESP_OKAY);
      driveIn <= 8'h5a;
      idle(4);
      check(32'(driveOut), 32'h5a);
      host.setFrame(1'b0);
      idle(3);
      rawDiag <= {8{8'h01}};
      driveIn <= 8'ha5;
      idle(4);
      diagAll(8'h01);
      readCheck(GCR_ADDR_STATUS, 8'h02, GCR_RESP_OKAY);
      check(32'(driveOut), 32'h5a);
      host.setFrame(1'b1);
      idle(3);
      check(32'(driveOut), 32'h5a);
      idle(GCR_REALIGN_CYCLES + 4);
      check(32'(driveOut), 32'ha5);
      for (int i = 0; i < 3; i++) begin
         axiWrite(GCR_ADDR_CONFIG, hwTab[i], GCR_RESP_OKAY);
         p = userPulses;
         host.strobe();
         idle(4);
         readCheck(GCR_ADDR_CONFIG, hwExp[i], GCR_RESP_OKAY);
         check(32'(userPulses - p), 32'(hwPulse[i]));
         check(32'(ledMatrixSerial), 32'(hwExp[i][GCR_BIT_LED_EN]));
      end
      p = userPulses;
      q = restartPulses;
      axiWrite(GCR_ADDR_CONFIG, 8'h05, GCR_RESP_OKAY);
      idle(3);
      readCheck(GCR_ADDR_CONFIG, 8'h00, GCR_RESP_OKAY);
      check(32'(ledMatrixSerial), 32'h0);
      check(32'(userPulses - p), 32'd1);
      check(32'(restartPulses - q), 32'd1);
      axiWrite(GCR_ADDR_CONFIG, 8'h00, GCR_RESP_OKAY);
      idle(3);
      check(32'(userPulses - p), 32'd1);
      summarize();
   end
endmodule
